// [verilog/efs_defines.svh]
// constants for the error-flag status and flag port block
// assumes inclusion by bare name from design files
`ifndef EFS_DEFINES_SVH
`define EFS_DEFINES_SVH
`define EFS_CNT_W 24
`define EFS_CNT_RST 24'h000000
`define EFS_ADDR_CNT_LOW 8'h11
`define EFS_HDR0 10'h000
`define EFS_HDR1 10'h3FF
`define EFS_HDR2 10'h3FF
`define EFS_HDR3 10'h1F4
`define EFS_SEL_FF 2'h0
`define EFS_SEL_AP 2'h1
`define EFS_SEL_ANC 2'h2
`define EFS_SEL_CTL 2'h3
`define EFS_MODE_NORMAL 2'h0
`define EFS_MODE_RESET 2'h1
`define EFS_MODE_AUTO 2'h2
`define EFS_MODE_HOLD 2'h3
`define EFS_LINE_UES 4
`define EFS_SENS_CHKSM 15
`endif

// [verilog/efs_pkg.sv]
// types shared by the error-flag status block
// assumes efs_defines.svh for numeric constants
package efs_pkg;
  // per-group flags, bit 4 unknown error down to bit 0 error here
  typedef logic [4:0] efs_group_type;
  typedef struct packed {
    efs_group_type ff;
    efs_group_type ap;
    efs_group_type anc;
  } efs_flags_type;
endpackage

// [verilog/efs_port_if.sv]
// flag port carrier between top and the flag port module
// assumes single sys_clk_in domain
`timescale 1ns/100ps
interface efs_port_if;
  logic wr_stb;
  logic [1:0] wr_sel;
  logic [4:0] wr_data;
  logic rd_src_in;
  modport port(output wr_stb, output wr_sel, output wr_data, output rd_src_in);
  modport core(input wr_stb, input wr_sel, input wr_data, input rd_src_in);
endinterface

// [verilog/efs_flag_port.sv]
// flag port pin logic: synchronisers, direction, read mux
// assumes pins come from outside the clock domain
`timescale 1ns/100ps
`include "efs_defines.svh"
module efs_flag_port (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic dir_pin_in,
  input wire logic [1:0] sel_pin_in,
  input wire logic [4:0] lines_pin_in,
  input wire efs_pkg::efs_flags_type in_flags_in,
  input wire efs_pkg::efs_flags_type out_flags_in,
  input wire logic chksm_err_in,
  input wire logic in_apv_in,
  input wire logic in_ffv_in,
  input wire logic s_bit_in,
  output logic [4:0] lines_out,
  output logic [4:0] lines_oe_n_out,
  efs_port_if.port pif
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic rd_src;
    logic [4:0] dout;
    logic oe_n;
  } efs_fp_state_type;
  efs_fp_state_type st_r;
  efs_fp_state_type st_nxt;

  function automatic logic [4:0] efs_pick(input efs_pkg::efs_flags_type f, input logic [1:0] s);
    logic [4:0] v;
    v = 5'h00;
    unique case (s)
      `EFS_SEL_FF: v = f.ff;
      `EFS_SEL_AP: v = f.ap;
      `EFS_SEL_ANC: v = f.anc;
      `EFS_SEL_CTL: v = 5'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    logic dir;
    logic [1:0] sel;
    dir = st_r.s2[7];
    sel = st_r.s2[6:5];
    st_nxt = st_r;
    // first stage feeds only the second
    st_nxt.s1 = {dir_pin_in, sel_pin_in, lines_pin_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.oe_n = ~dir;
    // first direction-low cycle only releases the lines, nothing is captured
    if (!dir && st_r.oe_n && sel == `EFS_SEL_CTL) begin
      st_nxt.rd_src = st_r.s2[4];
    end
    if (sel == `EFS_SEL_CTL) begin
      st_nxt.dout = {chksm_err_in, in_apv_in, in_ffv_in, s_bit_in, 1'b0};
    end else if (st_r.rd_src) begin
      st_nxt.dout = efs_pick(in_flags_in, sel);
    end else begin
      st_nxt.dout = efs_pick(out_flags_in, sel);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '{s1: 8'hFF, s2: 8'hFF, rd_src: 1'b0, dout: 5'h00, oe_n: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lines_out = st_r.dout;
  assign lines_oe_n_out = {5{st_r.oe_n}};
  // writes hand the first direction-low sample's successors to the core
  assign pif.wr_stb = ~st_r.s2[7] & st_r.oe_n;
  assign pif.wr_sel = st_r.s2[6:5];
  assign pif.wr_data = st_r.s2[4:0];
  assign pif.rd_src_in = st_r.rd_src;

  a_read_drives: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    st_r.s2[7] |=> !st_r.oe_n) else $error("port not driven in read");
  a_src_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !(!st_r.s2[7] && st_r.s2[6:5] == 2'h3) |=> $stable(st_r.rd_src))
    else $error("read source changed without write");
endmodule

// [verilog/efs_status.sv]
// error-flag status, missing packet, errored field counter, flag port
// assumes packet framing strobes from upstream logic on sys_clk_in
`timescale 1ns/100ps
`include "efs_defines.svh"
// Summary of operation
// - outgoing unknown flag set if incoming unknown high or, in receive mode, validity low
// - in receive mode, missing packet sets all three outgoing unknown flags
// - missing packet flag shows only fields lacking a packet, per field
// - packet present needs header 000 3FF 3FF 1F4 at expected position
// - 24-bit counter adds one per field with an enabled flag
// - sixteen sensitivity bits, error flag bits enable when low
// - checksum error sensitivity bit enables when high
// - mode 00 normal, 01 reset, 10 auto reset, 11 hold
// - reset mode clears counter then mode returns to normal
// - auto reset clears counter on read of low byte at address 17
// - hold mode forces zero until mode changes
// - five lines reach fifteen flags, group chosen by select
// - direction low makes lines inputs; writes go to next packet
// - port write beats host overwrite for one packet only
// - codes 00 01 10 pick full, active, ancillary groups
// - write code 11: read source, active valid, full valid
// - read source high reads incoming flags, low reads outgoing
// - read source latched until rewritten, low after reset
// - direction high drives selected group on lines
// - read code 11: checksum error line 4, status bit line 1
// - read code 11: incoming validity bits on lines 3 and 2
module efs_status (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic receive_mode_in,
  input wire logic field_end_in,
  input wire logic anc_hdr_stb_in,
  input wire logic [39:0] anc_hdr_in,
  input wire logic anc_pos_ok_in,
  input wire efs_pkg::efs_flags_type in_flags_in,
  input wire logic in_apv_in,
  input wire logic in_ffv_in,
  input wire logic chksm_err_in,
  input wire logic s_bit_in,
  input wire efs_pkg::efs_flags_type host_ovr_val_in,
  input wire efs_pkg::efs_flags_type host_ovr_en_in,
  input wire logic [15:0] sens_in,
  input wire logic [1:0] mode_in,
  input wire logic mode_wr_in,
  input wire logic host_rd_in,
  input wire logic [7:0] host_addr_in,
  input wire logic flag_port_direction_in,
  input wire logic [1:0] flag_group_select_in,
  input wire logic [4:0] flag_lines_in,
  output logic [4:0] flag_lines_out,
  output logic [4:0] flag_lines_oe_n_out,
  output efs_pkg::efs_flags_type out_flags_out,
  output logic out_apv_out,
  output logic out_ffv_out,
  output logic missing_packet_flag_out,
  output logic [1:0] counter_mode_sel_out,
  output logic [23:0] errored_field_count_out,
  output logic [7:0] errored_field_count_low_out
);
  typedef struct packed {
    logic seen;
    logic missing;
    efs_pkg::efs_flags_type out_flags;
    efs_pkg::efs_flags_type pend_val;
    efs_pkg::efs_flags_type pend_en;
    logic pend_apv;
    logic pend_ffv;
    logic pend_v_en;
    logic out_apv;
    logic out_ffv;
    logic [1:0] mode;
    logic [`EFS_CNT_W-1:0] cnt;
  } efs_state_type;
  efs_state_type st_r;
  efs_state_type st_nxt;
  efs_port_if pif();

  efs_flag_port u_port (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .dir_pin_in(flag_port_direction_in),
    .sel_pin_in(flag_group_select_in),
    .lines_pin_in(flag_lines_in),
    .in_flags_in(in_flags_in),
    .out_flags_in(st_r.out_flags),
    .chksm_err_in(chksm_err_in),
    .in_apv_in(in_apv_in),
    .in_ffv_in(in_ffv_in),
    .s_bit_in(s_bit_in),
    .lines_out(flag_lines_out),
    .lines_oe_n_out(flag_lines_oe_n_out),
    .pif(pif.port)
  );

  function automatic logic efs_hdr_ok(input logic [39:0] h);
    return h[39:30] == `EFS_HDR0 && h[29:20] == `EFS_HDR1 &&
      h[19:10] == `EFS_HDR2 && h[9:0] == `EFS_HDR3;
  endfunction

  function automatic logic efs_any(input efs_pkg::efs_flags_type f, input logic [15:0] s,
      input logic ck);
    // low bit enables a flag; checksum bit enables when high
    return |(f & ~s[14:0]) | (ck & s[`EFS_SENS_CHKSM]);
  endfunction

  function automatic efs_pkg::efs_flags_type efs_merge(input efs_pkg::efs_flags_type a,
      input efs_pkg::efs_flags_type b, input logic [4:0] m, input logic [1:0] s);
    efs_pkg::efs_flags_type r;
    r = a;
    unique case (s)
      `EFS_SEL_FF: r.ff = (a.ff & ~m) | (b.ff & m);
      `EFS_SEL_AP: r.ap = (a.ap & ~m) | (b.ap & m);
      `EFS_SEL_ANC: r.anc = (a.anc & ~m) | (b.anc & m);
      `EFS_SEL_CTL: r = a;
    endcase
    return r;
  endfunction

  always_comb begin
    efs_pkg::efs_flags_type f;
    efs_pkg::efs_flags_type w;
    logic present;
    f = in_flags_in;
    w = '0;
    present = 1'b0;
    st_nxt = st_r;
    if (anc_hdr_stb_in && efs_hdr_ok(anc_hdr_in) && anc_pos_ok_in) begin
      st_nxt.seen = 1'b1;
    end
    if (pif.wr_stb) begin
      w = {3{pif.wr_data}};
      if (pif.wr_sel == `EFS_SEL_CTL) begin
        st_nxt.pend_apv = pif.wr_data[3];
        st_nxt.pend_ffv = pif.wr_data[2];
        st_nxt.pend_v_en = 1'b1;
      end else begin
        st_nxt.pend_val = efs_merge(st_r.pend_val, w, 5'h1F, pif.wr_sel);
        st_nxt.pend_en = efs_merge(st_r.pend_en, '1, 5'h1F, pif.wr_sel);
      end
    end
    if (mode_wr_in) begin
      st_nxt.mode = mode_in;
    end
    if (field_end_in) begin
      present = st_r.seen;
      st_nxt.seen = 1'b0;
      st_nxt.missing = ~present;
      if (receive_mode_in) begin
        f.ff[`EFS_LINE_UES] = in_flags_in.ff[`EFS_LINE_UES] | ~in_ffv_in | ~present;
        f.ap[`EFS_LINE_UES] = in_flags_in.ap[`EFS_LINE_UES] | ~in_apv_in | ~present;
        f.anc[`EFS_LINE_UES] = in_flags_in.anc[`EFS_LINE_UES] | ~present;
      end
      f = (f & ~host_ovr_en_in) | (host_ovr_val_in & host_ovr_en_in);
      f = (f & ~st_r.pend_en) | (st_r.pend_val & st_r.pend_en);
      st_nxt.out_flags = f;
      st_nxt.out_apv = st_r.pend_v_en ? st_r.pend_apv : 1'b1;
      st_nxt.out_ffv = st_r.pend_v_en ? st_r.pend_ffv : 1'b1;
      st_nxt.pend_en = '0;
      st_nxt.pend_v_en = 1'b0;
      if (efs_any(f, sens_in, chksm_err_in) && st_r.mode != `EFS_MODE_HOLD) begin
        st_nxt.cnt = st_r.cnt + 24'h000001;
      end
    end
    unique case (st_r.mode)
      `EFS_MODE_NORMAL: ;
      `EFS_MODE_RESET: begin
        st_nxt.cnt = `EFS_CNT_RST;
        if (!mode_wr_in) begin
          st_nxt.mode = `EFS_MODE_NORMAL;
        end
      end
      `EFS_MODE_AUTO: begin
        if (host_rd_in && host_addr_in == `EFS_ADDR_CNT_LOW) begin
          st_nxt.cnt = `EFS_CNT_RST;
        end
      end
      `EFS_MODE_HOLD: st_nxt.cnt = `EFS_CNT_RST;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '{seen: 1'b0, missing: 1'b0, out_flags: '0, pend_val: '0, pend_en: '0,
        pend_apv: 1'b1, pend_ffv: 1'b1, pend_v_en: 1'b0, out_apv: 1'b1, out_ffv: 1'b1,
        mode: `EFS_MODE_NORMAL, cnt: `EFS_CNT_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_flags_out = st_r.out_flags;
  assign out_apv_out = st_r.out_apv;
  assign out_ffv_out = st_r.out_ffv;
  assign missing_packet_flag_out = st_r.missing;
  assign counter_mode_sel_out = st_r.mode;
  assign errored_field_count_out = st_r.cnt;
  assign errored_field_count_low_out = st_r.cnt[7:0];

  sequence s_field_no_pkt;
    field_end_in && !st_r.seen;
  endsequence
  a_missing_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_field_no_pkt |=> st_r.missing) else $error("missing flag not set");
  a_missing_clr: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    field_end_in && st_r.seen |=> !st_r.missing) else $error("missing flag stuck");
  a_ues_nopkt: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_field_no_pkt and (receive_mode_in && st_r.pend_en == '0 && host_ovr_en_in == '0)
    |=> st_r.out_flags.ff[4] && st_r.out_flags.ap[4] && st_r.out_flags.anc[4])
    else $error("unknown flags not set");
  a_hold_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    st_r.mode == 2'h3 |=> st_r.cnt == 24'h000000) else $error("hold not zero");
  a_reset_mode: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    st_r.mode == 2'h1 && !mode_wr_in |=> st_r.cnt == 24'h000000 && st_r.mode == 2'h0)
    else $error("reset mode wrong");
  a_auto_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    st_r.mode == 2'h2 && host_rd_in && host_addr_in == 8'h11 |=> st_r.cnt == 24'h000000)
    else $error("auto reset missed");
  a_cnt_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    st_r.mode == 2'h0 && !mode_wr_in && field_end_in |=>
    st_r.cnt == $past(st_r.cnt) || st_r.cnt == $past(st_r.cnt) + 24'h000001)
    else $error("counter step wrong");
  a_port_once: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    field_end_in && !pif.wr_stb |=> st_r.pend_en == '0) else $error("port write kept");
endmodule

// [testbench/efs_flag_ctrl.sv]
// model of the external flag controller on the flag port pins
// assumes the bench calls its tasks; pins change on the falling edge
`timescale 1ns/100ps
module efs_flag_ctrl (
  input wire logic sys_clk_in,
  input wire logic [4:0] lines_out_in,
  input wire logic [4:0] oe_n_in,
  output logic dir_out,
  output logic [1:0] sel_out,
  output logic [4:0] lines_in_out
);
  logic drv = 1'h0;
  logic [4:0] dat = 5'h00;
  logic [4:0] last = 5'h00;
  // idle: read direction, select held at a fixed level
  initial begin
    dir_out = 1'h1;
    sel_out = 2'h0;
  end
  // no pull resistor: an undriven line toggles instead of holding
  always_comb begin
    if (drv) lines_in_out = dat;
    else lines_in_out = (~oe_n_in & lines_out_in) | (oe_n_in & ~last);
  end
  always @(posedge sys_clk_in) last <= lines_in_out;
  task automatic wr(input logic [1:0] s, input logic [4:0] d);
    @(negedge sys_clk_in);
    dir_out = 1'h0;
    sel_out = s;
    // lines driven only once the device has let go of them
    repeat (3) @(negedge sys_clk_in);
    drv = 1'h1;
    dat = d;
    repeat (5) @(negedge sys_clk_in);
    dir_out = 1'h1;
    @(negedge sys_clk_in);
    drv = 1'h0;
  endtask
  task automatic rd(input logic [1:0] s, output logic [4:0] d, output logic [4:0] oe);
    @(negedge sys_clk_in);
    dir_out = 1'h1;
    sel_out = s;
    repeat (4) @(negedge sys_clk_in);
    d = lines_in_out;
    oe = oe_n_in;
  endtask
endmodule

// [testbench/tb_top.sv]
// bench for the error-flag status block with a flag controller model
// assumes efs_pkg compiled first; inputs change on the falling edge
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic rx = 1'h0, fe = 1'h0, hs = 1'h0, pos = 1'h0, mwr = 1'h0, hrd = 1'h0;
  logic cke = 1'h0, iapv = 1'h1, iffv = 1'h1, sb = 1'h0, m, dir, oapv, offv, miss;
  logic [39:0] hdr = 40'h0;
  logic [15:0] sens = 16'hFFFF;
  logic [1:0] mode = 2'h0, msel, gsel, k;
  logic [2:0] e3;
  logic [7:0] haddr = 8'h00, clow;
  logic [4:0] lin, lout, loe, d5, o5;
  logic [23:0] cnt, ecnt = 24'h0;
  efs_pkg::efs_flags_type inf = 15'h0, hval = 15'h0, hen = 15'h0, of, ue;
  int errors = 0, tests_run = 0, cyc = 0;
  efs_status efs_status_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .receive_mode_in(rx), .field_end_in(fe), .anc_hdr_stb_in(hs), .anc_hdr_in(hdr),
    .anc_pos_ok_in(pos), .in_flags_in(inf), .in_apv_in(iapv), .in_ffv_in(iffv),
    .chksm_err_in(cke), .s_bit_in(sb), .host_ovr_val_in(hval), .host_ovr_en_in(hen),
    .sens_in(sens), .mode_in(mode), .mode_wr_in(mwr), .host_rd_in(hrd),
    .host_addr_in(haddr), .flag_port_direction_in(dir), .flag_group_select_in(gsel),
    .flag_lines_in(lin), .flag_lines_out(lout), .flag_lines_oe_n_out(loe),
    .out_flags_out(of), .out_apv_out(oapv), .out_ffv_out(offv),
    .missing_packet_flag_out(miss), .counter_mode_sel_out(msel),
    .errored_field_count_out(cnt), .errored_field_count_low_out(clow));
  efs_flag_ctrl efs_flag_ctrl_i (.sys_clk_in(sys_clk_in), .lines_out_in(lout),
    .oe_n_in(loe), .dir_out(dir), .sel_out(gsel), .lines_in_out(lin));
  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // generous ceiling; the full run needs well under a thousand cycles
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic hit(efs_pkg::efs_flags_type f, logic [15:0] s, logic c);
    return (|(f & ~s[14:0])) | (c & s[15]);
  endfunction
  // k: 0 no packet, 1 good, 2 corrupt header, 3 wrong position
  task automatic field(input logic [1:0] k);
    logic [39:0] h;
    h = {10'h000, 10'h3FF, 10'h3FF, 10'h1F4};
    if (k == 2'h2) h[$urandom_range(39, 0)] ^= 1'h1;
    @(negedge sys_clk_in);
    hdr = h;
    pos = (k != 2'h3);
    hs = (k != 2'h0);
    @(negedge sys_clk_in);
    hs = 1'h0;
    fe = 1'h1;
    @(negedge sys_clk_in);
    fe = 1'h0;
    @(negedge sys_clk_in);
  endtask
  task automatic hostop(input logic w, input logic [7:0] a);
    @(negedge sys_clk_in);
    mode = a[1:0];
    haddr = a;
    mwr = w;
    hrd = !w;
    @(negedge sys_clk_in);
    mwr = 1'h0;
    hrd = 1'h0;
    @(negedge sys_clk_in);
  endtask
  initial begin
    void'($urandom(21));
    repeat (20) @(negedge sys_clk_in);
    rst_n_in = 1'h1;
    @(negedge sys_clk_in);
    check("reset state", 24'h0C0000, {4'h0, oapv, offv, miss, msel, of});
    check("reset count", 24'h0, cnt);
    inf = 15'h7FFF;
    efs_flag_ctrl_i.rd(2'h0, d5, o5);
    check("reset source", 24'h0, 24'(d5));
    rx = 1'h1;
    for (int i = 0; i < 24; i++) begin
      inf = 15'($urandom);
      iapv = 1'($urandom);
      iffv = 1'($urandom);
      k = (i < 4) ? 2'(i) : 2'($urandom_range(3, 0));
      field(k);
      m = (k != 2'h1);
      check("missing", 24'(m), 24'(miss));
      e3 = {m | inf.ff[4] | !iffv, m | inf.ap[4] | !iapv, m | inf.anc[4]};
      check("unknown", 24'(e3), 24'({of.ff[4], of.ap[4], of.anc[4]}));
    end
    rx = 1'h0;
    hen = 15'h7FFF;
    for (int i = 0; i < 30; i++) begin
      hval = (i == 1) ? 15'h7FFF : ((i == 0) ? 15'h0 : 15'($urandom));
      sens = (i == 0) ? 16'h8000 : ((i == 1) ? 16'h7FFF : 16'($urandom));
      cke = (i < 2) ? 1'h1 : 1'($urandom);
      field(2'h1);
      ecnt = ecnt + 24'(hit(hval, sens, cke));
      check("count", ecnt, cnt);
      check("low byte", 24'(ecnt[7:0]), 24'(clow));
      check("host flags", 24'(hval), 24'(of));
    end
    hval = 15'h0001;
    sens = 16'h0000;
    cke = 1'h0;
    hostop(1'h1, 8'h01);
    check("mode back", 24'h0, {msel, cnt[21:0]});
    field(2'h1);
    check("recount", 24'h1, cnt);
    hostop(1'h1, 8'h02);
    field(2'h1);
    hostop(1'h0, 8'h10);
    check("other read", 24'h2, cnt);
    hostop(1'h0, 8'h11);
    check("auto clear", 24'h0, cnt);
    field(2'h1);
    hostop(1'h1, 8'h03);
    field(2'h1);
    check("hold", 24'hC00000, {msel, cnt[21:0]});
    hostop(1'h1, 8'h00);
    field(2'h1);
    check("normal", 24'h1, cnt);
    hval = 15'($urandom);
    for (int g = 0; g < 3; g++) begin
      d5 = 5'($urandom);
      efs_flag_ctrl_i.wr(2'(g), d5);
      field(2'h1);
      ue = hval;
      ue[14 - 5 * g -: 5] = d5;
      check("port write", 24'(ue), 24'(of));
      field(2'h1);
      check("one packet", 24'(hval), 24'(of));
    end
    cke = 1'h1;
    sb = 1'($urandom);
    efs_flag_ctrl_i.wr(2'h3, 5'h10);
    field(2'h1);
    check("valid write", 24'h0, 24'({oapv, offv}));
    for (int s = 1; s >= 0; s--) begin
      efs_flag_ctrl_i.wr(2'h0, hval.ff);
      ue = s ? inf : hval;
      for (int g = 0; g < 4; g++) begin
        efs_flag_ctrl_i.rd(2'(g), d5, o5);
        check("drive", 24'h0, 24'(o5));
        e3 = s ? 3'h0 : 3'h4;
        if (g < 3) check("read group", 24'(ue[14 - 5 * g -: 5]), 24'(d5));
        else check("read ctl", 24'({cke, iapv, iffv, sb, 1'h0} & {e3[2], ~e3[1:0], 2'h3}),
          24'(d5 & {e3[2], ~e3[1:0], 2'h3}));
      end
      efs_flag_ctrl_i.wr(2'h3, 5'h0C);
      field(2'h1);
      check("valid back", 24'h3, 24'({oapv, offv}));
    end
    conclude();
  end
endmodule
